//--- rtl/rairr_regs.sv
// Right ADC input routing register bank with AHB-Lite slave
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "rairr_defines.svh"

module rairr_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [2:0] hburst,
	input wire logic [3:0] hprot,
	input wire logic hmastlock,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic right_input1_diff,
	output logic left_input1_diff,
	output logic right_adc_power_up,
	output rairr_pkg::rairr_level_t right_line1_level,
	output logic right_line1_connect,
	output rairr_pkg::rairr_level_t left_line1_level,
	output logic left_line1_connect,
	output logic gain_step_tick
);
	import rairr_pkg::*;

	// ************************************************
	// Declarations
	// ************************************************
	logic [7:0] right_ctrl;
	logic [7:0] rsvd_gap;
	logic [7:0] left_ctrl;
	logic [7:0] next_right_ctrl;
	logic [7:0] next_rsvd_gap;
	logic [7:0] next_left_ctrl;
	logic addr_phase;
	logic wr_pend;
	rairr_sel_t wr_sel;
	rairr_sel_t addr_sel;
	logic [7:0] wbyte;
	logic [15:0] div_cnt;
	logic sample_tick;
	logic half_phase;
	logic step_en;
	rairr_step_t step_mode;
	logic wr_right;
	logic wr_gap;
	logic wr_left;
	logic div_wrap;
	logic [7:0] rd_byte;
	rairr_level_t right_target;
	rairr_level_t left_target;

	// ************************************************
	// Functions
	// ************************************************
	function automatic rairr_sel_t decode(input logic [31:0] a);
		rairr_sel_t s;
		s = RAIRR_SEL_NONE;
		if (a[1:0] == 2'b00) begin
			if (a[31:2] == {22'h0, `RAIRR_IDX_RIGHT_CTRL})
				s = RAIRR_SEL_RIGHT;
			else if (a[31:2] == {22'h0, `RAIRR_IDX_RSVD_GAP})
				s = RAIRR_SEL_GAP;
			else if (a[31:2] == {22'h0, `RAIRR_IDX_LEFT_CTRL})
				s = RAIRR_SEL_LEFT;
		end
		return s;
	endfunction : decode

	function automatic logic [7:0] pick(input rairr_sel_t s,
		input logic [7:0] r, input logic [7:0] g, input logic [7:0] l);
		logic [7:0] v;
		v = 8'h00;
		case (s)
			RAIRR_SEL_RIGHT: v = r;
			RAIRR_SEL_GAP: v = g;
			RAIRR_SEL_LEFT: v = l;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : pick

	function automatic rairr_level_t level_of(input logic [7:0] r);
		return r[`RAIRR_LEVEL_MSB:`RAIRR_LEVEL_LSB];
	endfunction : level_of

	function automatic logic step_on(input rairr_step_t m);
		return (m == RAIRR_STEP_EVERY) || (m == RAIRR_STEP_EVERY2);
	endfunction : step_on

	// ************************************************
	// Address phase capture
	// ************************************************
	assign addr_phase = hsel && hready && htrans[1];
	assign addr_sel = decode(haddr);
	assign wbyte = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
		end else if (hready) begin
			// Only whole-word writes land
			wr_pend <= addr_phase && hwrite && (hsize == 3'b010);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_sel <= RAIRR_SEL_NONE;
		end else if (hready) begin
			wr_sel <= addr_sel;
		end
	end

	// ************************************************
	// Write strobes
	// ************************************************
	assign wr_right = wr_pend && (wr_sel == RAIRR_SEL_RIGHT);
	assign wr_gap = wr_pend && (wr_sel == RAIRR_SEL_GAP);
	assign wr_left = wr_pend && (wr_sel == RAIRR_SEL_LEFT);

	// ************************************************
	// Register next values
	// ************************************************
	always_comb begin
		next_right_ctrl = right_ctrl;
		if (wr_right)
			next_right_ctrl = wbyte;
	end

	always_comb begin
		next_rsvd_gap = rsvd_gap;
		if (wr_gap)
			next_rsvd_gap = wbyte;
	end

	always_comb begin
		next_left_ctrl = left_ctrl;
		if (wr_left)
			next_left_ctrl = wbyte & `RAIRR_LEFT_RSVD_MASK;
	end

	// ************************************************
	// Register storage
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			right_ctrl <= `RAIRR_RST_RIGHT_CTRL;
		end else begin
			right_ctrl <= next_right_ctrl;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsvd_gap <= `RAIRR_RST_RSVD_GAP;
		end else begin
			rsvd_gap <= next_rsvd_gap;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_ctrl <= `RAIRR_RST_LEFT_CTRL;
		end else begin
			left_ctrl <= next_left_ctrl;
		end
	end

	// ************************************************
	// Bus response
	// ************************************************
	// Read sees a write that completes on the same edge
	assign rd_byte = pick(addr_sel, next_right_ctrl, next_rsvd_gap,
		next_left_ctrl);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else begin
			// No wait states
			hreadyout <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			// Every transfer answers OKAY
			hresp <= 1'b0;
		end
	end

	// ************************************************
	// Static routing outputs
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			right_input1_diff <= 1'b0;
		end else begin
			right_input1_diff <= right_ctrl[`RAIRR_DIFF_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_input1_diff <= 1'b0;
		end else begin
			left_input1_diff <= left_ctrl[`RAIRR_DIFF_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			right_adc_power_up <= 1'b0;
		end else begin
			right_adc_power_up <= right_ctrl[`RAIRR_POWER_BIT];
		end
	end

	// ************************************************
	// Sample period divider
	// ************************************************
	assign div_wrap = (div_cnt == 16'(`RAIRR_SAMPLE_CYC - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 16'h0000;
		end else if (div_wrap) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= div_wrap;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_phase <= 1'b0;
		end else if (sample_tick) begin
			half_phase <= ~half_phase;
		end
	end

	// ************************************************
	// Soft-step rate select
	// ************************************************
	assign step_mode = rairr_step_t'(
		right_ctrl[`RAIRR_STEP_MSB:`RAIRR_STEP_LSB]);

	// Right ctrl step field serves both followers
	// Stepping off for codes 10 and 11
	assign step_en = step_on(step_mode);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_step_tick <= 1'b0;
		end else begin
			case (step_mode)
				RAIRR_STEP_EVERY: gain_step_tick <= sample_tick;
				RAIRR_STEP_EVERY2:
					gain_step_tick <= sample_tick && half_phase;
				default: gain_step_tick <= 1'b0;
			endcase
		end
	end

	// ************************************************
	// Level followers
	// ************************************************
	// Right and left level fields
	assign right_target = level_of(right_ctrl);
	assign left_target = level_of(left_ctrl);

	rairr_level_stepper u_right_step (
		.hclk(hclk),
		.hresetn(hresetn),
		.step_tick(gain_step_tick),
		.step_en(step_en),
		.target(right_target),
		.level(right_line1_level),
		.connect(right_line1_connect)
	);

	rairr_level_stepper u_left_step (
		.hclk(hclk),
		.hresetn(hresetn),
		.step_tick(gain_step_tick),
		.step_en(step_en),
		.target(left_target),
		.level(left_line1_level),
		.connect(left_line1_connect)
	);

endmodule : rairr_regs

//--- inc/rairr_defines.svh
// Offsets, field positions, reset values and timing of the routing registers
`ifndef RAIRR_DEFINES_SVH
`define RAIRR_DEFINES_SVH

// Register indices; byte address is four times the index
`define RAIRR_IDX_RIGHT_CTRL 8'h16
`define RAIRR_IDX_RSVD_GAP 8'h17
`define RAIRR_IDX_LEFT_CTRL 8'h18

// Field positions
`define RAIRR_DIFF_BIT 7
`define RAIRR_LEVEL_MSB 6
`define RAIRR_LEVEL_LSB 3
`define RAIRR_POWER_BIT 2
`define RAIRR_STEP_MSB 1
`define RAIRR_STEP_LSB 0
`define RAIRR_LEFT_RSVD_MASK 8'hf8

// Reset values
`define RAIRR_RST_RIGHT_CTRL 8'h78
`define RAIRR_RST_RSVD_GAP 8'h78
`define RAIRR_RST_LEFT_CTRL 8'h78

// Level codes
`define RAIRR_LEVEL_MAX 4'h8
`define RAIRR_LEVEL_DISC 4'hf

// Timing
`define RAIRR_CLK_HZ 40000000
`define RAIRR_SAMPLE_HZ 48000
`define RAIRR_SAMPLE_CYC (`RAIRR_CLK_HZ / `RAIRR_SAMPLE_HZ)

`endif

//--- inc/rairr_pkg.sv
// Types shared by the routing register bank and its gain stepper
package rairr_pkg;

	typedef logic [3:0] rairr_level_t;

	typedef enum logic [1:0] {
		RAIRR_STEP_EVERY = 2'b00,
		RAIRR_STEP_EVERY2 = 2'b01,
		RAIRR_STEP_OFF_A = 2'b10,
		RAIRR_STEP_OFF_B = 2'b11
	} rairr_step_t;

	typedef enum logic [1:0] {
		RAIRR_SEL_NONE = 2'b00,
		RAIRR_SEL_RIGHT = 2'b01,
		RAIRR_SEL_GAP = 2'b10,
		RAIRR_SEL_LEFT = 2'b11
	} rairr_sel_t;

	typedef enum logic [1:0] {
		RAIRR_STP_OFF = 2'b00,
		RAIRR_STP_SETTLED = 2'b01,
		RAIRR_STP_RAMP = 2'b10
	} rairr_stp_state_t;

endpackage : rairr_pkg

//--- rtl/rairr_level_stepper.sv
// Soft-stepping follower for one input level control
`timescale 1ns/1ps
`include "rairr_defines.svh"

module rairr_level_stepper (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step_tick,
	input wire logic step_en,
	input wire rairr_pkg::rairr_level_t target,
	output rairr_pkg::rairr_level_t level,
	output logic connect
);
	import rairr_pkg::*;

	rairr_stp_state_t state;
	logic target_valid;

	// Codes 9..14 are undefined; treated as disconnect
	assign target_valid = (target <= `RAIRR_LEVEL_MAX);

	// ************************************************
	// Level follower
	// ************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= RAIRR_STP_OFF;
			level <= `RAIRR_LEVEL_MAX;
			connect <= 1'b0;
		end else begin
			case (state)
				RAIRR_STP_OFF: begin
					// With stepping on, reconnect starts from deepest attenuation; with it off, the level goes straight to target
					if (target_valid) begin
						connect <= 1'b1;
						if (step_en) begin
							level <= `RAIRR_LEVEL_MAX;
							state <= RAIRR_STP_RAMP;
						end else begin
							level <= target;
							state <= RAIRR_STP_SETTLED;
						end
					end
				end
				RAIRR_STP_SETTLED, RAIRR_STP_RAMP: begin
					if (!target_valid) begin
						connect <= 1'b0;
						level <= `RAIRR_LEVEL_MAX;
						state <= RAIRR_STP_OFF;
					end else if (!step_en) begin
						level <= target;
						state <= RAIRR_STP_SETTLED;
					end else if (level == target) begin
						state <= RAIRR_STP_SETTLED;
					end else if (step_tick) begin
						level <= (level < target) ? level + 4'h1
							: level - 4'h1;
						state <= RAIRR_STP_RAMP;
					end else begin
						state <= RAIRR_STP_RAMP;
					end
				end
				default: begin
					state <= RAIRR_STP_OFF;
					connect <= 1'b0;
					level <= `RAIRR_LEVEL_MAX;
				end
			endcase
		end
	end

endmodule : rairr_level_stepper

//--- tb/rairr_regs_monitor.sv
// Port checks for the routing register bank
`timescale 1ns/1ps
module rairr_regs_monitor (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic right_input1_diff,
	input wire logic right_adc_power_up,
	input wire rairr_pkg::rairr_level_t right_line1_level,
	input wire logic right_line1_connect,
	input wire rairr_pkg::rairr_level_t left_line1_level,
	input wire logic left_line1_connect,
	input wire logic gain_step_tick
);
	import rairr_pkg::*;
	// ****************
	// Checks
	// ****************
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_addr(logic [31:0] a, logic w);
		hsel && hready && htrans[1] && hwrite == w && haddr == a
			&& hsize == 3'h2;
	endsequence
	property p_wr_right;
		logic [7:0] d;
		s_addr(32'h58, 1'b1) ##1 (1'b1, d = hwdata[7:0]) |-> ##[1:3]
			(right_input1_diff == d[7] && right_adc_power_up == d[2]);
	endproperty
	a_ready_always: assert property (hreadyout)
		else $error("wait state seen");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_right_level: assert property (
		right_line1_level <= 4'h8
		&& (right_line1_connect || right_line1_level == 4'h8))
		else $error("right level out of range");
	a_left_level: assert property (
		left_line1_level <= 4'h8
		&& (left_line1_connect || left_line1_level == 4'h8))
		else $error("left level out of range");
	a_tick_pulse: assert property (
		gain_step_tick |=> !gain_step_tick [*8])
		else $error("step tick too close");
	a_left_rsvd: assert property (
		s_addr(32'h60, 1'b0) |=> hrdata[2:0] == 3'h0 && hrdata[31:8] == 24'h0)
		else $error("left reserved bits not zero");
	a_write_follow: assert property (p_wr_right)
		else $error("pairing or power not following");
	a_reset_state: assert property (
		$rose(hresetn) |-> !right_line1_connect && !left_line1_connect
		&& !right_adc_power_up)
		else $error("outputs wrong after reset");
endmodule : rairr_regs_monitor
bind rairr_regs rairr_regs_monitor rairr_regs_monitor_i (.*);

//--- tb/rairr_regs_test.sv
// Self-checking bench for the routing register bank
`timescale 1ns/1ps
`include "rairr_defines.svh"
module rairr_regs_test;
	import rairr_pkg::*;
	localparam logic [31:0] RA = `RAIRR_IDX_RIGHT_CTRL * 4;
	localparam logic [31:0] GA = `RAIRR_IDX_RSVD_GAP * 4;
	localparam logic [31:0] LA = `RAIRR_IDX_LEFT_CTRL * 4;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic hmastlock = 1'b0, hreadyout, hresp, gain_step_tick;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, hburst = 3'h0;
	logic [3:0] hprot = 4'h0;
	logic right_input1_diff, left_input1_diff, right_adc_power_up;
	logic right_line1_connect, left_line1_connect;
	rairr_level_t right_line1_level, left_line1_level;
	wire logic hready = hreadyout;
	logic [7:0] mdl [3];
	logic [12:0] e;
	int miscompares = 0, compares = 0, n, i;
	int codes [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 15};
	logic [31:0] adr [5] = '{RA, GA, LA, 32'h64, 32'h59};
	rairr_regs rairr_regs_i (.*);
	always #12.5 hclk = ~hclk;
	// ****************
	// Tasks
	// ****************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic [2:0] sz);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		if (w && sz == 3'h2 && a inside {RA, GA, LA})
			mdl[(a - RA) >> 2] = d[7:0] & (a == LA ? 8'hf8 : 8'hff);
	endtask : xfer
	task automatic chk_rd(input logic [31:0] a);
		xfer(1'b0, a, 32'h0, 3'h2);
		cmp(rd, a inside {RA, GA, LA} ? {24'h0, mdl[(a - RA) >> 2]} : 32'h0);
	endtask : chk_rd
	function automatic logic [12:0] exp_pins(input logic [7:0] r,
		input logic [7:0] l);
		exp_pins = {r[7], l[7], r[2], r[6:3] <= 8, l[6:3] <= 8,
			r[6:3] <= 8 ? r[6:3] : 4'h8, l[6:3] <= 8 ? l[6:3] : 4'h8};
	endfunction : exp_pins
	task automatic chk_pins(input logic [12:0] x);
		@(negedge hclk);
		cmp({19'h0, right_input1_diff, left_input1_diff, right_adc_power_up,
			right_line1_connect, left_line1_connect, right_line1_level,
			left_line1_level}, {19'h0, x});
	endtask : chk_pins
	task automatic wait_tick(output int k);
		k = 0;
		do begin
			@(negedge hclk);
			k++;
		end while (gain_step_tick !== 1'b1 && k < 4000);
	endtask : wait_tick
	task automatic close_out;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (40000) @(posedge hclk);
		miscompares++;
		close_out;
	end
	initial begin
		i = $urandom(32'hd752c38a);
		mdl = '{`RAIRR_RST_RIGHT_CTRL, `RAIRR_RST_RSVD_GAP, `RAIRR_RST_LEFT_CTRL};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		chk_pins(exp_pins(mdl[0], mdl[2]));
		foreach (adr[j]) chk_rd(adr[j]);
		xfer(1'b1, RA, 32'hff, 3'h0);
		chk_rd(RA);
		for (i = 0; i < 10; i++) begin
			xfer(1'b1, RA, ($urandom & 32'h85) | 32'h2 | (codes[i] << 3), 3'h2);
			xfer(1'b1, LA, ($urandom & 32'h80) | (codes[9 - i] << 3), 3'h2);
			chk_rd(LA);
			chk_rd(RA);
			chk_pins(exp_pins(mdl[0], mdl[2]));
		end
		xfer(1'b1, RA, 32'h78, 3'h2);
		wait_tick(n);
		xfer(1'b1, RA, 32'h0, 3'h2);
		@(posedge hclk);
		e = exp_pins(mdl[0], mdl[2]);
		e[7:4] = 4'h8;
		chk_pins(e);
		for (i = 1; i < 9; i++) begin
			wait_tick(n);
			if (i > 1)
				cmp(n + 2, `RAIRR_SAMPLE_CYC);
			@(negedge hclk);
			e[7:4] = 4'(8 - i);
			chk_pins(e);
		end
		xfer(1'b1, RA, 32'h1, 3'h2);
		wait_tick(n);
		wait_tick(n);
		cmp(n, 2 * `RAIRR_SAMPLE_CYC);
		xfer(1'b1, RA, 32'h2, 3'h2);
		wait_tick(n);
		cmp(n, 4000);
		close_out;
	end
endmodule : rairr_regs_test
